// ==== rtl/seoe_consts.vh ====
// Constants for the enclave opt-in and enumeration block
`ifndef SEOE_CONSTS_VH
`define SEOE_CONSTS_VH

`define SEOE_LEAF_FEATURES   32'h0000_0007
`define SEOE_LEAF_ENCLAVE    32'h0000_0012
`define SEOE_FLAG_BIT        2
`define SEOE_FC_LOCK_BIT     0
`define SEOE_FC_OPTIN_BIT    18
`define SEOE_FC_RESET        64'h0000_0000_0000_0000
`define SEOE_SUB_CAPS        32'h0000_0000
`define SEOE_SUB_ATTR        32'h0000_0001
`define SEOE_SUB_SECT_FIRST  32'h0000_0002
`define SEOE_TYPE_INVALID    4'h0
`define SEOE_TYPE_SECTION    4'h1
`define SEOE_PROT_CONF_INTEG 4'h1
`define SEOE_FAULT_NONE      2'h0
`define SEOE_FAULT_UD        2'h1
`define SEOE_FAULT_GP        2'h2

`endif

// ==== rtl/seoe_enum.v ====
// Enclave opt-in control, feature-control register and leaf 12H enumeration
`timescale 1ns/10ps
`default_nettype none
`include "seoe_consts.vh"
module seoe_enum #(
	parameter SECT_AW = 2
) (
	input  wire               clk_i,
	input  wire               nrst_i,
	// Per-thread configuration
	input  wire               feature_flag_i,
	input  wire               enclave_gen_one_i,
	input  wire               enclave_gen_two_i,
	input  wire [31:0]        misc_feature_select_i,
	input  wire [7:0]         max_size_log2_legacy_i,
	input  wire [7:0]         max_size_log2_long_i,
	input  wire [127:0]       attr_settable_i,
	// Section table load
	input  wire               sect_we_i,
	input  wire [SECT_AW-1:0] sect_waddr_i,
	input  wire [39:0]        sect_base_i,
	input  wire [39:0]        sect_size_i,
	input  wire [SECT_AW:0]   sect_count_i,
	// Feature-control register access
	input  wire               fc_wr_i,
	input  wire [63:0]        fc_wdata_i,
	output reg  [63:0]        fc_rdata_o,
	// Identification query
	input  wire               query_i,
	input  wire [31:0]        query_leaf_i,
	input  wire [31:0]        query_sub_i,
	output reg                result_valid_o,
	output reg  [31:0]        result_a_o,
	output reg  [31:0]        result_b_o,
	output reg  [31:0]        result_c_o,
	output reg  [31:0]        result_d_o,
	// Enclave instruction check
	input  wire               enclave_op_i,
	output reg                op_done_o,
	output reg  [1:0]         op_fault_o,
	output reg                opted_in_o
);
	//--------------------------------------------------------------
	// Reset release
	//--------------------------------------------------------------
	reg rst_s1_q;
	reg rst_s2_q;
	wire rst_n = rst_s2_q;

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	//--------------------------------------------------------------
	// Feature-control register
	//--------------------------------------------------------------
	reg  lock_q;
	reg  optin_q;
	wire opted_in = lock_q & optin_q;

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			lock_q  <= 1'b0;
			optin_q <= 1'b0;
		end else if (fc_wr_i && !lock_q) begin
			// Opt-in follows lock write rules: only while unlocked
			lock_q  <= fc_wdata_i[`SEOE_FC_LOCK_BIT];
			optin_q <= fc_wdata_i[`SEOE_FC_OPTIN_BIT];
		end
	end

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			fc_rdata_o <= `SEOE_FC_RESET;
			opted_in_o <= 1'b0;
		end else begin
			fc_rdata_o <= 64'h0;
			fc_rdata_o[`SEOE_FC_LOCK_BIT]  <= lock_q;
			fc_rdata_o[`SEOE_FC_OPTIN_BIT] <= optin_q;
			opted_in_o <= opted_in;
		end
	end

	//--------------------------------------------------------------
	// Enclave instruction gating
	//--------------------------------------------------------------
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			op_done_o  <= 1'b0;
			op_fault_o <= `SEOE_FAULT_NONE;
		end else begin
			op_done_o <= enclave_op_i;
			if (!enclave_op_i) begin
				op_fault_o <= `SEOE_FAULT_NONE;
			end else if (!feature_flag_i) begin
				op_fault_o <= `SEOE_FAULT_UD;
			end else if (!opted_in) begin
				op_fault_o <= `SEOE_FAULT_GP;
			end else begin
				op_fault_o <= `SEOE_FAULT_NONE;
			end
		end
	end

	//--------------------------------------------------------------
	// Section table
	//--------------------------------------------------------------
	// Sections are 4 KB granular, so only address bits 51:12 are kept
	wire [SECT_AW-1:0] sect_idx;
	wire [79:0]        sect_rdata;
	wire [31:0]        sub_rel = query_sub_i - `SEOE_SUB_SECT_FIRST;
	assign sect_idx = sub_rel[SECT_AW-1:0];

	seoe_section_mem #(
		.AW (SECT_AW),
		.DW (80)
	) u_mem (
		.clk_i   (clk_i),
		.we_i    (sect_we_i),
		.waddr_i (sect_waddr_i),
		.wdata_i ({sect_size_i, sect_base_i}),
		.raddr_i (sect_idx),
		.rdata_o (sect_rdata)
	);

	//--------------------------------------------------------------
	// Query pipeline: stage one classifies, stage two muxes memory
	//--------------------------------------------------------------
	localparam ST_NONE = 3'h0;
	localparam ST_FEAT = 3'h1;
	localparam ST_CAPS = 3'h2;
	localparam ST_ATTR = 3'h3;
	localparam ST_SECT = 3'h4;

	reg [2:0] kind_q;
	reg       pend_q;
	wire      sect_in_range = (sub_rel < {{(31-SECT_AW){1'b0}}, sect_count_i});

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
			kind_q <= ST_NONE;
		end else begin
			pend_q <= query_i;
			kind_q <= ST_NONE;
			if (query_leaf_i == `SEOE_LEAF_FEATURES && query_sub_i == 32'h0) begin
				kind_q <= ST_FEAT;
			end else if (query_leaf_i == `SEOE_LEAF_ENCLAVE && feature_flag_i) begin
				// Sections are withheld until opted in
				if (query_sub_i == `SEOE_SUB_CAPS) begin
					kind_q <= ST_CAPS;
				end else if (query_sub_i == `SEOE_SUB_ATTR) begin
					kind_q <= ST_ATTR;
				end else if (opted_in && sect_in_range) begin
					kind_q <= ST_SECT;
				end
			end
		end
	end

	// Result words; registers are per instance, so one per hardware thread
	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			result_valid_o <= 1'b0;
			result_a_o     <= 32'h0;
			result_b_o     <= 32'h0;
			result_c_o     <= 32'h0;
			result_d_o     <= 32'h0;
		end else begin
			result_valid_o <= pend_q;
			result_a_o     <= 32'h0;
			result_b_o     <= 32'h0;
			result_c_o     <= 32'h0;
			result_d_o     <= 32'h0;
			if (pend_q) begin
				case (kind_q)
				ST_FEAT: begin
					// Opt-in bit is deliberately absent here
					result_b_o[`SEOE_FLAG_BIT] <= feature_flag_i;
				end
				ST_CAPS: begin
					result_a_o <= {30'h0, enclave_gen_two_i, enclave_gen_one_i};
					result_b_o <= misc_feature_select_i;
					result_d_o <= {16'h0, max_size_log2_long_i, max_size_log2_legacy_i};
				end
				ST_ATTR: begin
					result_a_o <= attr_settable_i[31:0];
					result_b_o <= attr_settable_i[63:32];
					result_c_o <= attr_settable_i[95:64];
					result_d_o <= attr_settable_i[127:96];
				end
				ST_SECT: begin
					result_a_o <= {sect_rdata[19:0], 8'h0, `SEOE_TYPE_SECTION};
					result_b_o <= {12'h0, sect_rdata[39:20]};
					result_c_o <= {sect_rdata[59:40], 8'h0, `SEOE_PROT_CONF_INTEG};
					result_d_o <= {12'h0, sect_rdata[79:60]};
				end
				default: begin
					result_a_o <= 32'h0;
				end
				endcase
			end
		end
	end
endmodule // seoe_enum
`default_nettype wire

// ==== rtl/seoe_section_mem.v ====
// Section table memory: base and size per protected section, registered read
`timescale 1ns/10ps
`default_nettype none
module seoe_section_mem #(
	parameter AW = 2,
	parameter DW = 80
) (
	input  wire          clk_i,
	input  wire          we_i,
	input  wire [AW-1:0] waddr_i,
	input  wire [DW-1:0] wdata_i,
	input  wire [AW-1:0] raddr_i,
	output reg  [DW-1:0] rdata_o
);
	reg [DW-1:0] mem_q [0:(1<<AW)-1];

	always @(posedge clk_i) begin
		if (we_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
		rdata_o <= mem_q[raddr_i];
	end
endmodule // seoe_section_mem
`default_nettype wire

// ==== tb/seoe_enum_sva.sv ====
// Port assertions for the enclave enumeration block
`timescale 1ns/10ps
`default_nettype none
module seoe_enum_sva (
	input wire logic        clk_i,
	input wire logic        nrst_i,
	input wire logic        feature_flag_i,
	input wire logic        query_i,
	input wire logic        enclave_op_i,
	input wire logic [63:0] fc_rdata_o,
	input wire logic        result_valid_o,
	input wire logic        op_done_o,
	input wire logic [1:0]  op_fault_o,
	input wire logic        opted_in_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// ----
	// Fault checks key on visible lock and opt-in bits only, as internal state leads them
	// ----
	AST_OPTIN: assert property (opted_in_o == (fc_rdata_o[0] && fc_rdata_o[18]))
		else $error("opted_in mismatch");
	AST_FC_BITS: assert property ((fc_rdata_o & ~64'h0000_0000_0004_0001) == 64'h0)
		else $error("fc stray bits");
	AST_LOCK: assert property (fc_rdata_o[0] |=> $stable(fc_rdata_o))
		else $error("locked fc changed");
	AST_QLAT: assert property (query_i |-> ##2 result_valid_o)
		else $error("no result");
	AST_QONLY: assert property (result_valid_o |-> $past(query_i, 2))
		else $error("stray result");
	AST_OPLAT: assert property (enclave_op_i |=> op_done_o)
		else $error("no op_done");
	AST_UD: assert property (enclave_op_i && !feature_flag_i |=> op_fault_o == 2'h1)
		else $error("expected invalid opcode");
	AST_GP: assert property (enclave_op_i && feature_flag_i && fc_rdata_o[0] && !fc_rdata_o[18]
		|=> op_fault_o == 2'h2) else $error("expected protection fault");
	AST_RUN: assert property (enclave_op_i && feature_flag_i && opted_in_o |=> op_fault_o == 2'h0)
		else $error("expected execute");
endmodule // seoe_enum_sva
bind seoe_enum seoe_enum_sva seoe_enum_sva_inst (.clk_i, .nrst_i, .feature_flag_i, .query_i, .enclave_op_i,
	.fc_rdata_o, .result_valid_o, .op_done_o, .op_fault_o, .opted_in_o);
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the enclave enumeration block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic         clk_i, nrst_i, feature_flag_i, enclave_gen_one_i, enclave_gen_two_i, sect_we_i, fc_wr_i;
	logic         query_i, enclave_op_i, result_valid_o, op_done_o, opted_in_o;
	logic [31:0]  misc_feature_select_i, query_leaf_i, query_sub_i, result_a_o, result_b_o, result_c_o, result_d_o;
	logic [7:0]   max_size_log2_legacy_i, max_size_log2_long_i;
	logic [127:0] attr_settable_i;
	logic [1:0]   sect_waddr_i, op_fault_o;
	logic [2:0]   sect_count_i;
	logic [39:0]  sect_base_i, sect_size_i, mb[4], ms[4];
	logic [63:0]  fc_wdata_i, fc_rdata_o;
	int           err_total, checks_done, lk, en;
	seoe_enum seoe_enum_inst (.clk_i, .nrst_i, .feature_flag_i, .enclave_gen_one_i, .enclave_gen_two_i,
		.misc_feature_select_i, .max_size_log2_legacy_i, .max_size_log2_long_i, .attr_settable_i, .sect_we_i,
		.sect_waddr_i, .sect_base_i, .sect_size_i, .sect_count_i, .fc_wr_i, .fc_wdata_i, .fc_rdata_o, .query_i,
		.query_leaf_i, .query_sub_i, .result_valid_o, .result_a_o, .result_b_o, .result_c_o, .result_d_o,
		.enclave_op_i, .op_done_o, .op_fault_o, .opted_in_o);
	initial begin
		clk_i = 0;
		forever #5 clk_i = ~clk_i;
	end
	// ----
	// Model and checks
	// ----
	task chk(string n, logic [127:0] e, logic [127:0] s);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_sim;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	function logic [127:0] em(int lf, int sb);
		em = 128'h0;
		if (lf == 7 && sb == 0)
			em[34] = feature_flag_i;
		else if (lf == 'h12 && feature_flag_i) begin
			if (sb == 0)
				em = {16'h0, max_size_log2_long_i, max_size_log2_legacy_i, 32'h0, misc_feature_select_i,
					30'h0, enclave_gen_two_i, enclave_gen_one_i};
			else if (sb == 1)
				em = attr_settable_i;
			else if (lk && en && sb - 2 < sect_count_i)
				em = {12'h0, ms[sb-2][39:20], ms[sb-2][19:0], 12'h1, 12'h0, mb[sb-2][39:20], mb[sb-2][19:0], 12'h1};
		end
	endfunction
	task qry(int lf, int sb);
		@(negedge clk_i);
		query_i = 1;
		query_leaf_i = lf;
		query_sub_i = sb;
		@(negedge clk_i);
		query_i = 0;
		@(negedge clk_i);
		chk("valid", 1, result_valid_o);
		chk("words", em(lf, sb), {result_d_o, result_c_o, result_b_o, result_a_o});
	endtask
	task op;
		@(negedge clk_i);
		enclave_op_i = 1;
		@(negedge clk_i);
		enclave_op_i = 0;
		chk("op_done", 1, op_done_o);
		chk("op_fault", !feature_flag_i ? 1 : (lk && en ? 0 : 2), op_fault_o);
	endtask
	task fcw(logic [63:0] w);
		@(negedge clk_i);
		fc_wr_i = 1;
		fc_wdata_i = w;
		if (!lk) begin
			lk = w[0];
			en = w[18];
		end
		@(negedge clk_i);
		fc_wr_i = 0;
		@(negedge clk_i);
		chk("fc_rdata", (en << 18) | lk, fc_rdata_o);
		chk("opted_in", lk && en, opted_in_o);
	endtask
	task rst;
		nrst_i = 0;
		lk = 0;
		en = 0;
		repeat (16) @(negedge clk_i);
		nrst_i = 1;
		repeat (3) @(negedge clk_i);
		chk("fc_rdata_rst", 0, fc_rdata_o);
	endtask
	initial begin
		{feature_flag_i, sect_we_i, fc_wr_i, query_i, enclave_op_i, sect_waddr_i, sect_count_i} = 0;
		{query_leaf_i, query_sub_i, fc_wdata_i, sect_base_i, sect_size_i} = 0;
		err_total = 0;
		checks_done = 0;
		void'($urandom(32'hB24C));
		{enclave_gen_one_i, enclave_gen_two_i} = 2'($urandom);
		{max_size_log2_legacy_i, max_size_log2_long_i} = 16'($urandom);
		misc_feature_select_i = $urandom;
		attr_settable_i = {$urandom, $urandom, $urandom, $urandom};
		rst;
		op;
		qry('h12, 0);
		feature_flag_i = 1;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk_i);
			sect_we_i = 1;
			sect_waddr_i = 2'(i);
			sect_base_i = 40'({$urandom, $urandom});
			sect_size_i = 40'({$urandom, $urandom});
			mb[i] = sect_base_i;
			ms[i] = sect_size_i;
		end
		@(negedge clk_i);
		sect_we_i = 0;
		sect_count_i = 3;
		qry(7, 0);
		for (int s = 0; s < 4; s++) qry('h12, s);
		op;
		fcw(64'h40000);
		op;
		fcw(64'h40001);
		qry(7, 0);
		op;
		for (int s = 0; s < 6; s++) qry('h12, s);
		fcw(64'h0);
		rst;
		fcw(64'h1);
		fcw(64'h40001);
		op;
		qry('h12, 2);
		end_sim;
	end
endmodule // testbench
`default_nettype wire
